/* File: disturbance_record_capture.sv */
// disturbance record capture controller with apb register slave
`timescale 1ns/100ps
`include "drc_defs.svh"
module disturbance_record_capture
  import drc_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = `DRC_SAMPLE_DIV_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`DRC_TRIG_N-1:0] trig_in,
  input wire sample_s sample_in,
  output logic sample_strobe,
  output logic recording,
  output logic memory_full
);
  localparam int unsigned DEPTH = `DRC_MEM_DEPTH;
  localparam logic [`DRC_AW:0] DEPTH_W = 19'(DEPTH);

  // apb and configuration group
  logic ack_r, ack_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic ovw_r, ovw_nxt;
  logic [`DRC_TRIG_N-1:0] trig_en_r, trig_en_nxt;
  logic [`DRC_LW-1:0] limit_r, limit_nxt;
  logic [`DRC_PCT_W-1:0] pre_pct_r, pre_pct_nxt, post_pct_r, post_pct_nxt;
  logic [`DRC_SW-1:0] sel_r, sel_nxt;
  logic [`DRC_AW-1:0] maddr_r, maddr_nxt;
  logic wr_acc, man_wr, clr_wr, del_wr, mapped;
  logic [`DRC_LW-1:0] wlimit;
  logic [`DRC_PCT_W-1:0] wpre, wpost;

  // capture group
  cap_state_e st_r, st_nxt;
  logic [`DRC_DIV_W-1:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  logic [`DRC_AW-1:0] wp_r, wp_nxt, start_r, start_nxt;
  logic [`DRC_LW-1:0] cnt_r, cnt_nxt, post_r, post_nxt, hist_r, hist_nxt;
  logic [`DRC_TRIG_N-1:0] cause_r, cause_nxt;
  logic man_r, man_nxt, full_r, full_nxt;
  logic [`DRC_SW-1:0] head_r, head_nxt, tail_r, tail_nxt;
  logic [`DRC_NW-1:0] num_r, num_nxt;
  rec_entry_s tab_r [`DRC_SLOTS];
  rec_entry_s tab_nxt [`DRC_SLOTS];
  logic [`DRC_SLOTS-1:0] rv_r, rv_nxt;
  logic mem_we;
  sample_s mem [DEPTH];
  sample_s mem_q_r;

  logic [22:0] pre_prod, post_prod;
  logic [`DRC_LW-1:0] pre_len, post_len;
  logic [`DRC_AW:0] gap, gap_raw, st_raw;
  logic room, idle_like, slots_full, need_free, removing;
  logic [`DRC_TRIG_N-1:0] act;

  // durations derived from limit and percentages
  always_comb begin
    pre_prod = 23'(limit_r * pre_pct_r);
    post_prod = 23'(limit_r * post_pct_r);
    pre_len = 16'(pre_prod / 23'(`DRC_PCT_FULL));
    post_len = 16'(post_prod / 23'(`DRC_PCT_FULL));
  end

  // apb slave, one wait state
  always_comb begin
    ack_nxt = psel & penable & ~ack_r;
    wr_acc = psel & penable & ack_r & pwrite;
    man_wr = wr_acc && paddr == `DRC_OFS_CTRL && pwdata[`DRC_CTRL_MAN];
    clr_wr = wr_acc && paddr == `DRC_OFS_CTRL && pwdata[`DRC_CTRL_CLR];
    del_wr = wr_acc && paddr == `DRC_OFS_CTRL && pwdata[`DRC_CTRL_DEL];
    mapped = paddr[1:0] == 2'h0 && paddr <= `DRC_OFS_DUR;
    ovw_nxt = ovw_r;
    trig_en_nxt = trig_en_r;
    limit_nxt = limit_r;
    pre_pct_nxt = pre_pct_r;
    post_pct_nxt = post_pct_r;
    sel_nxt = sel_r;
    maddr_nxt = maddr_r;
    prdata_nxt = prdata_r;
    wlimit = pwdata[`DRC_LW-1:0];
    wpre = pwdata[`DRC_PCT_W-1:0];
    wpost = pwdata[`DRC_PCT_POST_LO +: `DRC_PCT_W];
    if (wlimit > 16'(`DRC_LIMIT_MAX)) begin
      wlimit = 16'(`DRC_LIMIT_MAX);
    end
    if (wlimit == 16'h0000) begin
      wlimit = 16'h0001;
    end
    if (wpre > `DRC_PCT_FULL) begin
      wpre = `DRC_PCT_FULL;
    end
    if (wpost > `DRC_PCT_FULL) begin
      wpost = `DRC_PCT_FULL;
    end
    if (wr_acc) begin
      case (paddr)
        `DRC_OFS_CTRL: begin
          ovw_nxt = pwdata[`DRC_CTRL_OVW];
          sel_nxt = pwdata[`DRC_CTRL_SEL_LO +: `DRC_SW];
        end
        `DRC_OFS_TRIG_EN: trig_en_nxt = pwdata[`DRC_TRIG_N-1:0];
        `DRC_OFS_LIMIT: limit_nxt = wlimit;
        `DRC_OFS_PCT: begin
          pre_pct_nxt = wpre;
          post_pct_nxt = wpost;
        end
        `DRC_OFS_MEM_ADDR: maddr_nxt = pwdata[`DRC_AW-1:0];
        default: ;
      endcase
    end
    // unmapped accesses of either direction answer with zero data
    if (ack_nxt && (!pwrite || !mapped)) begin
      case (paddr)
        `DRC_OFS_CTRL: prdata_nxt = {20'h0, sel_r, 7'h0, ovw_r};
        `DRC_OFS_TRIG_EN: prdata_nxt = {24'h0, trig_en_r};
        `DRC_OFS_LIMIT: prdata_nxt = {16'h0, limit_r};
        `DRC_OFS_PCT: prdata_nxt = {17'h0, post_pct_r, 1'b0, pre_pct_r};
        `DRC_OFS_STATUS: prdata_nxt = {20'h0, man_r, 2'h0, num_r, full_r, st_r};
        `DRC_OFS_WPTR: prdata_nxt = {14'h0, wp_r};
        `DRC_OFS_SEL_START: prdata_nxt = {rv_r[sel_r], 13'h0, tab_r[sel_r].start};
        `DRC_OFS_SEL_LEN: prdata_nxt = {16'h0, tab_r[sel_r].len};
        `DRC_OFS_MEM_ADDR: prdata_nxt = {14'h0, maddr_r};
        `DRC_OFS_MEM_DATA: prdata_nxt = mem_q_r;
        `DRC_OFS_DUR: prdata_nxt = {post_len, pre_len};
        default: prdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
      prdata_r <= 32'h0;
      ovw_r <= 1'b0;
      trig_en_r <= `DRC_TRIG_EN_RST;
      limit_r <= `DRC_LIMIT_RST;
      pre_pct_r <= `DRC_PRE_RST;
      post_pct_r <= `DRC_POST_RST;
      sel_r <= '0;
      maddr_r <= '0;
    end else if (ce) begin
      ack_r <= ack_nxt;
      prdata_r <= prdata_nxt;
      ovw_r <= ovw_nxt;
      trig_en_r <= trig_en_nxt;
      limit_r <= limit_nxt;
      pre_pct_r <= pre_pct_nxt;
      post_pct_r <= post_pct_nxt;
      sel_r <= sel_nxt;
      maddr_r <= maddr_nxt;
    end
  end

  assign pready = ack_r;
  assign pslverr = ack_r & ~mapped;
  assign prdata = prdata_r;

  // free space ahead of the write pointer up to the oldest record
  always_comb begin
    gap_raw = {1'b0, tab_r[tail_r].start} + DEPTH_W - {1'b0, wp_r};
    gap = (gap_raw >= DEPTH_W) ? gap_raw - DEPTH_W : gap_raw;
    if (num_r == '0) begin
      gap = DEPTH_W;
    end
    room = gap > {3'h0, limit_r};
    st_raw = {1'b0, wp_r} + 19'h1 + DEPTH_W - {3'h0, pre_len};
    if (st_raw >= DEPTH_W) begin
      st_raw = st_raw - DEPTH_W;
    end
    act = trig_in & trig_en_r;
    idle_like = st_r == ST_IDLE || st_r == ST_LOCK;
    slots_full = num_r == 5'(`DRC_SLOTS);
    need_free = idle_like && (!room || slots_full);
  end

  // capture state machine and record table
  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r + 17'h1;
    tick_nxt = 1'b0;
    wp_nxt = wp_r;
    start_nxt = start_r;
    cnt_nxt = cnt_r;
    post_nxt = post_r;
    hist_nxt = hist_r;
    cause_nxt = cause_r;
    man_nxt = man_r | man_wr;
    head_nxt = head_r;
    tail_nxt = tail_r;
    num_nxt = num_r;
    tab_nxt = tab_r;
    rv_nxt = rv_r;
    mem_we = 1'b0;
    removing = 1'b0;
    full_nxt = need_free && !ovw_r;
    if (div_r == 17'(SAMPLE_DIV - 1)) begin
      div_nxt = '0;
      tick_nxt = 1'b1;
    end
    case (st_r)
      ST_IDLE, ST_LOCK: begin
        if (tick_r && room) begin
          mem_we = 1'b1;
          if (hist_r != 16'hffff) begin
            hist_nxt = hist_r + 16'h1;
          end
        end
        if (st_r == ST_LOCK) begin
          if ((cause_r & trig_in) == '0) begin
            st_nxt = ST_IDLE;
          end
        end else if (tick_r && room && !slots_full && hist_r >= pre_len &&
                     (act != '0 || man_r)) begin
          start_nxt = st_raw[`DRC_AW-1:0];
          cnt_nxt = pre_len;
          post_nxt = '0;
          cause_nxt = act;
          man_nxt = man_wr;
          st_nxt = ST_EVENT;
        end
      end
      ST_EVENT: begin
        if (cnt_r >= limit_r) begin
          st_nxt = ST_STORE;
        end else if ((cause_r & trig_in) == '0) begin
          st_nxt = ST_POST;
        end else if (tick_r) begin
          mem_we = 1'b1;
          cnt_nxt = cnt_r + 16'h1;
        end
      end
      ST_POST: begin
        if (cnt_r >= limit_r || post_r >= post_len) begin
          st_nxt = ST_STORE;
        end else if (tick_r) begin
          mem_we = 1'b1;
          cnt_nxt = cnt_r + 16'h1;
          post_nxt = post_r + 16'h1;
        end
      end
      ST_STORE: begin
        tab_nxt[head_r].start = start_r;
        tab_nxt[head_r].len = cnt_r;
        rv_nxt[head_r] = 1'b1;
        head_nxt = head_r + 4'h1;
        st_nxt = ST_LOCK;
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (mem_we) begin
      wp_nxt = (wp_r == 18'(DEPTH - 1)) ? '0 : wp_r + 18'h1;
    end
    if (num_r != '0 && !rv_r[tail_r]) begin
      removing = 1'b1;
      tail_nxt = tail_r + 4'h1;
    end else if (need_free && ovw_r && num_r != '0) begin
      rv_nxt[tail_r] = 1'b0;
    end
    // a slot being stored in this cycle keeps its valid bit
    if (del_wr && !(st_r == ST_STORE && sel_r == head_r)) begin
      rv_nxt[sel_r] = 1'b0;
    end
    num_nxt = num_r + 5'(st_r == ST_STORE) - 5'(removing);
    if (clr_wr) begin
      rv_nxt = '0;
      num_nxt = '0;
      tail_nxt = head_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      div_r <= '0;
      tick_r <= 1'b0;
      wp_r <= '0;
      start_r <= '0;
      cnt_r <= '0;
      post_r <= '0;
      hist_r <= '0;
      cause_r <= '0;
      man_r <= 1'b0;
      full_r <= 1'b0;
      head_r <= '0;
      tail_r <= '0;
      num_r <= '0;
      rv_r <= '0;
      for (int i = 0; i < `DRC_SLOTS; i++) begin
        tab_r[i] <= '0;
      end
    end else if (ce) begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      wp_r <= wp_nxt;
      start_r <= start_nxt;
      cnt_r <= cnt_nxt;
      post_r <= post_nxt;
      hist_r <= hist_nxt;
      cause_r <= cause_nxt;
      man_r <= man_nxt;
      full_r <= full_nxt;
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      num_r <= num_nxt;
      rv_r <= rv_nxt;
      tab_r <= tab_nxt;
    end
  end

  // sample memory, no reset
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (mem_we) begin
        mem[wp_r] <= sample_in;
      end
      mem_q_r <= mem[maddr_r];
    end
  end

  assign sample_strobe = tick_r;
  assign recording = st_r == ST_EVENT || st_r == ST_POST;
  assign memory_full = full_r;
endmodule

/* File: drc_defs.svh */
// constants of the disturbance record capture block
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define DRC_CLK_HZ 125000000
`define DRC_FUND_HZ 50
`define DRC_SMP_PER_CYC 32
`define DRC_SAMPLE_DIV_CYC (`DRC_CLK_HZ / (`DRC_FUND_HZ * `DRC_SMP_PER_CYC))
`define DRC_MEM_SEC 120
`define DRC_MEM_DEPTH (`DRC_MEM_SEC * `DRC_FUND_HZ * `DRC_SMP_PER_CYC)
`define DRC_LIMIT_SEC 15
`define DRC_LIMIT_MAX (`DRC_LIMIT_SEC * `DRC_FUND_HZ * `DRC_SMP_PER_CYC)
`define DRC_AW 18
`define DRC_LW 16
`define DRC_DIV_W 17
`define DRC_SLOTS 16
`define DRC_SW 4
`define DRC_NW 5
`define DRC_TRIG_N 8
`define DRC_PCT_W 7
`define DRC_PCT_FULL 7'h64
`define DRC_OFS_CTRL 8'h00
`define DRC_OFS_TRIG_EN 8'h04
`define DRC_OFS_LIMIT 8'h08
`define DRC_OFS_PCT 8'h0c
`define DRC_OFS_STATUS 8'h10
`define DRC_OFS_WPTR 8'h14
`define DRC_OFS_SEL_START 8'h18
`define DRC_OFS_SEL_LEN 8'h1c
`define DRC_OFS_MEM_ADDR 8'h20
`define DRC_OFS_MEM_DATA 8'h24
`define DRC_OFS_DUR 8'h28
`define DRC_CTRL_OVW 0
`define DRC_CTRL_MAN 1
`define DRC_CTRL_CLR 2
`define DRC_CTRL_DEL 3
`define DRC_CTRL_SEL_LO 8
`define DRC_PCT_POST_LO 8
`define DRC_LIMIT_RST 16'h0c80
`define DRC_PRE_RST 7'h0a
`define DRC_POST_RST 7'h14
`define DRC_TRIG_EN_RST 8'hff
`endif

/* File: drc_partner.sv */
// protection logic model: trigger levels and a sample stream
`timescale 1ns/100ps
module drc_partner
  import drc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] trig_req,
  output logic [7:0] trig_in,
  output sample_s sample_in
);
  logic [15:0] phase_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 16'h0000;
      trig_in <= 8'h00;
    end else begin
      phase_r <= phase_r + 16'h0001;
      trig_in <= trig_req;
    end
  end
  // analog and digital traces of one instant travel together, changing every cycle
  assign sample_in = {~phase_r, phase_r};
endmodule

/* File: drc_pkg.sv */
// types shared by the disturbance record capture block
`include "drc_defs.svh"
package drc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_EVENT = 3'h1,
    ST_POST = 3'h3,
    ST_STORE = 3'h2,
    ST_LOCK = 3'h6
  } cap_state_e;
  typedef struct packed {
    logic [15:0] digital;
    logic [15:0] analog;
  } sample_s;
  typedef struct packed {
    logic [`DRC_AW-1:0] start;
    logic [`DRC_LW-1:0] len;
  } rec_entry_s;
endpackage

/* File: drc_props.sv */
// concurrent checks on the ports of the disturbance record capture block
`timescale 1ns/100ps
`include "drc_defs.svh"
module drc_props
  import drc_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = 8
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_strobe,
  input wire logic recording,
  input wire logic memory_full
);
  logic [31:0] div_r;
  logic seen_r;
  logic [15:0] len_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
      seen_r <= 1'b0;
      len_r <= '0;
    end else if (ce) begin
      // frozen cycles do not count towards the strobe spacing
      div_r <= (sample_strobe || !seen_r) ? '0 : div_r + 32'h1;
      seen_r <= seen_r | sample_strobe;
      len_r <= !recording ? '0 : len_r + {15'h0, sample_strobe};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  strobe_spacing_a: assert property (ce && sample_strobe && seen_r |-> div_r == SAMPLE_DIV - 1)
    else $error("sample strobe spacing off");
  apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  start_on_strobe_a: assert property ($rose(recording) |-> $past(sample_strobe))
    else $error("record started off a strobe");
  relock_gap_a: assert property ($fell(recording) |-> !recording [*3])
    else $error("record restarted without lock");
  full_block_a: assert property (memory_full && !recording |=> !recording)
    else $error("record started while full");
  length_cap_a: assert property (len_r <= `DRC_LIMIT_MAX)
    else $error("record longer than limit");
  cover property ($rose(recording));
  cover property ($fell(recording));
  cover property (pslverr);
endmodule
bind disturbance_record_capture drc_props #(.SAMPLE_DIV(SAMPLE_DIV)) chk (.pclk, .presetn,
  .ce, .psel, .penable, .prdata, .pready, .pslverr, .sample_strobe, .recording, .memory_full);

/* File: tb_top.sv */
// self-checking bench for the disturbance record capture block
`timescale 1ns/100ps
module tb_top;
  import drc_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} row_s;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00, trig_req = 8'h00, trig_in;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sample_strobe, recording, memory_full;
  sample_s sample_in;
  int n_mismatch = 0, num_checks = 0;
  row_s rows[14] = '{'{0, 8'h04, 0, 32'hff, 0}, '{0, 8'h08, 0, 32'h0c80, 0},
    '{0, 8'h0c, 0, 32'h140a, 0}, '{0, 8'h00, 0, 32'h0, 0}, '{0, 8'h10, 0, 32'h0, 0},
    '{1, 8'h08, 32'h0, 0, 0}, '{0, 8'h08, 0, 32'h1, 0}, '{1, 8'h08, 32'hffff, 0, 0},
    '{0, 8'h08, 0, 32'h5dc0, 0}, '{1, 8'h0c, 32'h7f7f, 0, 0}, '{0, 8'h0c, 0, 32'h6464, 0},
    '{1, 8'h08, 32'h28, 0, 0}, '{1, 8'h0c, 32'h140a, 0, 0}, '{0, 8'h28, 0, 32'h00080004, 0}};
  initial begin
    forever #4 pclk = ~pclk;
  end
  disturbance_record_capture #(.SAMPLE_DIV(8)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
    .sample_in(sample_in), .sample_strobe(sample_strobe), .recording(recording),
    .memory_full(memory_full));
  drc_partner far (.pclk(pclk), .presetn(presetn), .trig_req(trig_req), .trig_in(trig_in),
    .sample_in(sample_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    check(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_rec(input logic lvl);
    int k;
    k = 0;
    while (recording !== lvl && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    check(recording, lvl);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      check(err, rows[i].er);
      if (!rows[i].wr) check(rd, rows[i].e);
    end
    apb(1'b0, 8'h2c, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, 8'h02, 32'h5);
    check(err, 1'b1);
    @(posedge pclk iff sample_strobe);
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    check(sample_strobe, 1'b0);
    ce <= 1'b1;
    repeat (7) @(posedge pclk);
    check(sample_strobe, 1'b0);
    @(posedge pclk);
    check(sample_strobe, 1'b1);
    trig_req <= 8'h01;
    wait_rec(1'b1);
    wait_rec(1'b0);
    repeat (100) @(posedge pclk);
    check(recording, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check(rd[2:0], 3'h6);
    apb(1'b0, 8'h1c, 32'h0);
    check(rd, 32'd40);
    apb(1'b0, 8'h18, 32'h0);
    check(rd[31], 1'b1);
    trig_req <= 8'h00;
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    check(rd[8:0], 9'h010);
    apb(1'b1, 8'h00, 32'h2);
    wait_rec(1'b1);
    wait_rec(1'b0);
    apb(1'b1, 8'h00, 32'h100);
    apb(1'b0, 8'h1c, 32'h0);
    check(rd, 32'd12);
    apb(1'b1, 8'h04, 32'hfe);
    trig_req <= 8'h01;
    repeat (100) @(posedge pclk);
    check(recording, 1'b0);
    trig_req <= 8'h80;
    wait_rec(1'b1);
    trig_req <= 8'h00;
    wait_rec(1'b0);
    repeat (20) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h108);
    apb(1'b0, 8'h18, 32'h0);
    check(rd[31], 1'b0);
    apb(1'b1, 8'h00, 32'h4);
    apb(1'b0, 8'h10, 32'h0);
    check(rd[8:4], 5'h0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 8'h00, 32'h2);
      wait_rec(1'b1);
      wait_rec(1'b0);
    end
    repeat (5) @(posedge pclk);
    check(memory_full, 1'b1);
    apb(1'b1, 8'h00, 32'h2);
    repeat (100) @(posedge pclk);
    check(recording, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check(rd[11:3], 9'h121);
    apb(1'b1, 8'h00, 32'h1);
    wait_rec(1'b1);
    wait_rec(1'b0);
    repeat (5) @(posedge pclk);
    check(memory_full, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check(rd[11:3], 9'h01e);
    presetn <= 1'b0;
    @(posedge pclk);
    check({pready, pslverr, sample_strobe, recording, memory_full}, 32'h0);
    check(prdata, 32'h0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0c80);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    conclude();
  end
endmodule
